// ---- pfl_fastlock_lock.sv ----
/*
 Fast-lock timer, slip reduction select, edge lock detector and pump voltage
 monitor behind a classic Wishbone slave.
 Assumes ref_edge and fb_edge are asynchronous pulses (stretched beyond two
 clocks), edge_gap_ps is a measured phase gap and the comparator levels are
 asynchronous; all pass two flip-flops before use.
*/
`timescale 1ns/1ps
module pfl_fastlock_lock
   import pfl_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Loop edges and measurement
   input  wire logic        ref_edge,
   input  wire logic        fb_edge,
   input  wire logic [15:0] edge_gap_ps,
   input  wire logic        ramp_speedup_active,
   // Pump comparators
   input  wire logic        pump_below_low,
   input  wire logic        pump_above_high,
   // Outputs to the loop
   output logic      [4:0]  pump_gain,
   output logic      [1:0]  slip_reduction,
   output logic             speedup_active,
   output logic             edge_lock_detect,
   output logic             combined_lock_indication,
   output logic             irq
);
   logic [7:0]  slip_ctrl;
   logic [4:0]  normal_pump_gain;
   logic [7:0]  gain_timer_high;
   logic [7:0]  timer_low;
   logic [5:0]  pump_volt_low_limit;
   logic [5:0]  pump_volt_high_limit;
   logic [7:0]  lock_good_edge_count;
   logic [7:0]  lock_error_window;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [2:0]  ref_sync;
   logic [2:0]  fb_sync;
   logic [1:0]  low_sync;
   logic [1:0]  high_sync;
   logic [15:0] gap_meta;
   logic [15:0] gap;
   logic [15:0] speedup_cnt;
   logic [7:0]  good_cnt;
   logic [4:0]  bad_cnt;
   logic        ref_rise;
   logic        fb_rise;
   logic        wr;
   logic        rd_fb_n_write;
   logic [7:0]  idx;
   logic [10:0] speedup_timer_count;
   logic [15:0] win_ps;
   logic        pump_ok;
   logic        speeding;
   logic        lock_prev;
   logic        speed_prev;
   logic [IRQ_W-1:0] events;
   logic [31:0] next_rdata;

   assign idx = wb_adr_i[9:2];
   // A write lands on the edge where the master samples ack high, never earlier
   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign rd_fb_n_write = wr && (idx == ADDR_FEEDBACK_N);
   assign speedup_timer_count = {gain_timer_high[7:5], timer_low};
   assign ref_rise = ref_sync[1] && !ref_sync[2];
   assign fb_rise  = fb_sync[1] && !fb_sync[2];
   assign pump_ok  = !low_sync[1] && !high_sync[1];

   // Synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ref_sync  <= 3'h0;
         fb_sync   <= 3'h0;
         low_sync  <= 2'h0;
         high_sync <= 2'h0;
         gap_meta  <= 16'h0000;
         gap       <= 16'h0000;
      end else begin
         ref_sync  <= {ref_sync[1:0], ref_edge};
         fb_sync   <= {fb_sync[1:0], fb_edge};
         low_sync  <= {low_sync[0], pump_below_low};
         high_sync <= {high_sync[0], pump_above_high};
         gap_meta  <= edge_gap_ps;
         gap       <= gap_meta;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slip_ctrl            <= RST_SLIP_CTRL;
         normal_pump_gain     <= 5'h00;
         gain_timer_high      <= RST_GAIN_TIMERH;
         timer_low            <= RST_TIMER_LOW;
         pump_volt_low_limit  <= RST_LOW_LIMIT;
         pump_volt_high_limit <= RST_HIGH_LIMIT;
         lock_good_edge_count <= RST_PASS_COUNT;
         lock_error_window    <= RST_ERR_WINDOW;
         irq_mask             <= '0;
      end else if (wr) begin
         unique case (idx)
            ADDR_SLIP_CTRL:   slip_ctrl            <= wb_dat_i[7:0];
            ADDR_NORM_GAIN:   normal_pump_gain     <= wb_dat_i[4:0];
            ADDR_GAIN_TIMERH: gain_timer_high      <= wb_dat_i[7:0];
            ADDR_PUMP_LOW:    pump_volt_low_limit  <= wb_dat_i[5:0];
            ADDR_PUMP_HIGH:   pump_volt_high_limit <= wb_dat_i[5:0];
            ADDR_TIMER_LOW:   timer_low            <= wb_dat_i[7:0];
            ADDR_PASS_COUNT:  lock_good_edge_count <= wb_dat_i[7:0];
            ADDR_ERR_WINDOW:  lock_error_window    <= wb_dat_i[7:0];
            ADDR_IRQ_MASK:    irq_mask             <= wb_dat_i[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Speedup timer, one step per reference edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         speedup_cnt <= 16'h0000;
      end else if (rd_fb_n_write) begin
         // Zero field leaves the timer idle
         speedup_cnt <= 16'({5'h00, speedup_timer_count} * TIMER_SCALE);
      end else if (ref_rise && speedup_cnt != 16'h0000) begin
         speedup_cnt <= speedup_cnt - 16'h0001;
      end
   end

   assign speeding = (speedup_cnt != 16'h0000) || ramp_speedup_active;

   // Gain and slip outputs; reserved factor is treated as off
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pump_gain      <= 5'h00;
         slip_reduction <= PFL_SLIP_OFF;
         speedup_active <= 1'b0;
      end else begin
         speedup_active <= speeding;
         pump_gain      <= speeding ? gain_timer_high[4:0] : normal_pump_gain;
         if (speeding && slip_ctrl[6:5] != PFL_SLIP_RSV) begin
            slip_reduction <= slip_ctrl[6:5];
         end else begin
            slip_reduction <= PFL_SLIP_OFF;
         end
      end
   end

   // Window lookup in picoseconds; reserved codes give no good edges
   always_comb begin
      unique case (lock_error_window[7:5])
         3'h0:    win_ps = 16'd1000;
         3'h1:    win_ps = 16'd1700;
         3'h2:    win_ps = 16'd3000;
         3'h3:    win_ps = 16'd6000;
         3'h4:    win_ps = 16'd10000;
         3'h5:    win_ps = 16'd18000;
         default: win_ps = 16'd0;
      endcase
   end

   // Edge lock detector, judged at each feedback edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         good_cnt         <= 8'h00;
         bad_cnt          <= 5'h00;
         edge_lock_detect <= 1'b0;
      end else if (fb_rise) begin
         if (gap < win_ps) begin
            if (good_cnt >= lock_good_edge_count) begin
               edge_lock_detect <= 1'b1;
               bad_cnt          <= 5'h00;
            end else begin
               good_cnt <= good_cnt + 8'h01;
            end
         end else if (bad_cnt >= lock_error_window[4:0]) begin
            edge_lock_detect <= 1'b0;
            good_cnt         <= 8'h00;
            bad_cnt          <= 5'h00;
         end else begin
            bad_cnt <= bad_cnt + 5'h01;
         end
      end
   end

   // Combined lock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         combined_lock_indication <= 1'b0;
      end else begin
         combined_lock_indication <= edge_lock_detect && pump_ok;
      end
   end

   // Interrupt events; set beats write-one-to-clear
   assign events[IRQ_LOCK_GAIN]  = edge_lock_detect && !lock_prev;
   assign events[IRQ_LOCK_LOSS]  = !edge_lock_detect && lock_prev;
   assign events[IRQ_SPEED_DONE] = !speeding && speed_prev;
   assign events[IRQ_PUMP_BAD]   = !pump_ok;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lock_prev  <= 1'b0;
         speed_prev <= 1'b0;
         irq_status <= '0;
         irq        <= 1'b0;
      end else begin
         lock_prev  <= edge_lock_detect;
         speed_prev <= speeding;
         if (wr && idx == ADDR_IRQ_STATUS) begin
            irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | events;
         end else begin
            irq_status <= irq_status | events;
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (idx)
         ADDR_SLIP_CTRL:   next_rdata[7:0] = slip_ctrl;
         ADDR_NORM_GAIN:   next_rdata[4:0] = normal_pump_gain;
         ADDR_GAIN_TIMERH: next_rdata[7:0] = gain_timer_high;
         ADDR_PUMP_LOW:    next_rdata[7:0] = {1'b0, !low_sync[1], pump_volt_low_limit};
         ADDR_PUMP_HIGH:   next_rdata[7:0] = {1'b0, high_sync[1], pump_volt_high_limit};
         ADDR_TIMER_LOW:   next_rdata[7:0] = timer_low;
         ADDR_PASS_COUNT:  next_rdata[7:0] = lock_good_edge_count;
         ADDR_ERR_WINDOW:  next_rdata[7:0] = lock_error_window;
         ADDR_IRQ_STATUS:  next_rdata[IRQ_W-1:0] = irq_status;
         ADDR_IRQ_MASK:    next_rdata[IRQ_W-1:0] = irq_mask;
         ADDR_STATUS:      next_rdata[3:0] = {pump_ok, speeding, combined_lock_indication,
                                              edge_lock_detect};
         default: ;
      endcase
   end

   // One wait state: ack one cycle after the request, dropped the next
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= next_rdata;
      end
   end
endmodule

// ---- pfl_fastlock_lock_sva.sv ----
/* Port-level checker for pfl_fastlock_lock.
 Assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
module pfl_fastlock_lock_sva (
   // Clock, reset, bus
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic       wb_cyc_i,
   input wire logic       wb_stb_i,
   input wire logic       wb_ack_o,
   // Loop side
   input wire logic       ref_edge,
   input wire logic       fb_edge,
   input wire logic       ramp_speedup_active,
   input wire logic       pump_below_low,
   input wire logic       pump_above_high,
   input wire logic [1:0] slip_reduction,
   input wire logic       speedup_active,
   input wire logic       edge_lock_detect,
   input wire logic       combined_lock_indication,
   input wire logic       irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack");
   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_comb_src; combined_lock_indication |-> $past(edge_lock_detect); endproperty
   a_comb_src: assert property (p_comb_src) else $error("lock without edge lock");
   property p_low_drop; pump_below_low [*6] |-> !combined_lock_indication; endproperty
   a_low_drop: assert property (p_low_drop) else $error("lock with pump low");
   property p_high_drop; pump_above_high [*6] |-> !combined_lock_indication; endproperty
   a_high_drop: assert property (p_high_drop) else $error("lock with pump high");
   // Ramp is sampled raw, so the slip factor lags it by one clock
   property p_slip_cause;
      slip_reduction != 2'b00 |-> speedup_active || $past(ramp_speedup_active);
   endproperty
   a_slip_cause: assert property (p_slip_cause) else $error("slip while idle");
   property p_slip_rsv; slip_reduction != 2'b11; endproperty
   a_slip_rsv: assert property (p_slip_rsv) else $error("reserved slip");
   property p_speed_end;
      $fell(speedup_active) |-> $past(ref_edge, 3) || $past(ref_edge, 4) || $past(ref_edge, 5)
         || $past(ramp_speedup_active, 2);
   endproperty
   a_speed_end: assert property (p_speed_end) else $error("speedup end off ref");
   property p_lock_fb;
      $changed(edge_lock_detect) |-> $past(fb_edge, 3) || $past(fb_edge, 4) || $past(fb_edge, 5);
   endproperty
   a_lock_fb: assert property (p_lock_fb) else $error("lock change off fb");
   c_lock: cover property ($rose(edge_lock_detect));
   c_speed: cover property ($fell(speedup_active));
   c_irq: cover property ($rose(irq));
endmodule
bind pfl_fastlock_lock pfl_fastlock_lock_sva pfl_fastlock_lock_sva_inst (.clk, .rstn,
   .wb_cyc_i, .wb_stb_i, .wb_ack_o, .ref_edge, .fb_edge, .ramp_speedup_active,
   .pump_below_low, .pump_above_high, .slip_reduction, .speedup_active,
   .edge_lock_detect, .combined_lock_indication, .irq);

// ---- pfl_fastlock_lock_tb.sv ----
/* Testbench for pfl_fastlock_lock: registers, speedup timer, lock, pump monitor, irq.
 Assumes the checker file is compiled with it; edges are held four clocks. */
`timescale 1ns/1ps
module pfl_fastlock_lock_tb;
   import pfl_pkg::*;
   logic        clk, rstn, cyc, stb, we, rf, fb, ramp, lo, hi, ack, spd, elock, comb, irq;
   logic [9:0]  adr;
   logic [31:0] wdat, rdat;
   logic [15:0] gap;
   logic [4:0]  gain;
   logic [1:0]  slip;
   logic [7:0]  q;
   int          err_total, cmp_count;
   always #2.5 clk = ~clk;
   pfl_fastlock_lock pfl_fastlock_lock_inst (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .ref_edge(rf), .fb_edge(fb), .edge_gap_ps(gap),
      .ramp_speedup_active(ramp), .pump_below_low(lo), .pump_above_high(hi),
      .pump_gain(gain), .slip_reduction(slip), .speedup_active(spd),
      .edge_lock_detect(elock), .combined_lock_indication(comb), .irq(irq));
   task automatic end_sim;
      $display("errors %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ck(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {a, 2'b00};
      wdat <= {24'h0, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 50) begin
         err_total++;
         end_sim();
      end
      @(posedge clk);
   endtask
   // Ref edge, and feedback edge when f is set, rise together; gap tells the detector how far apart they were
   task automatic pulse(input int k, input logic f);
      repeat (k) begin
         rf <= 1'b1;
         fb <= f;
         repeat (4) @(posedge clk);
         rf <= 1'b0;
         fb <= 1'b0;
         repeat (4) @(posedge clk);
      end
   endtask
   task automatic t_regs;
      logic [7:0] a[8] = '{8'h1b, 8'h1d, 8'h20, 8'h21, 8'h22, 8'h1e, 8'h1f, 8'h3f};
      logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h4a, 8'h32, 8'h00};
      for (int i = 0; i < 8; i++) begin
         wb(a[i], 1'b0, 8'h00);
         ck("reset value", e[i], q);
      end
   endtask
   task automatic t_flags;
      lo <= 1'b1;
      hi <= 1'b1;
      wb(ADDR_PUMP_LOW, 1'b1, 8'hff);
      wb(ADDR_PUMP_LOW, 1'b0, 8'h00);
      ck("low flag", 8'h3f, q);
      wb(ADDR_PUMP_HIGH, 1'b0, 8'h00);
      ck("high flag", 8'h72, q);
      lo <= 1'b0;
      hi <= 1'b0;
   endtask
   task automatic t_speed;
      logic [1:0] ex[4] = '{2'd0, 2'd1, 2'd2, 2'd0};
      wb(ADDR_NORM_GAIN, 1'b1, 8'h03);
      wb(ADDR_GAIN_TIMERH, 1'b1, 8'h1f);
      wb(ADDR_TIMER_LOW, 1'b1, 8'h01);
      for (int s = 0; s < 4; s++) begin
         wb(ADDR_SLIP_CTRL, 1'b1, {1'b0, 2'(s), 5'h00});
         wb(ADDR_FEEDBACK_N, 1'b1, 8'h00);
         repeat (2) @(posedge clk);
         ck("speedup", 8'h01, 8'(spd));
         ck("fast gain", 8'h1f, 8'(gain));
         ck("slip", 8'(ex[s]), 8'(slip));
         pulse(31, 1'b0);
         ck("still speeding", 8'h01, 8'(spd));
         pulse(1, 1'b0);
         ck("speedup end", 8'h00, 8'(spd));
         ck("normal gain", 8'h03, 8'(gain));
         ck("slip off", 8'h00, 8'(slip));
      end
      wb(ADDR_FEEDBACK_N, 1'b1, 8'h00);
      pulse(20, 1'b0);
      wb(ADDR_FEEDBACK_N, 1'b1, 8'h00);
      pulse(31, 1'b0);
      ck("restarted", 8'h01, 8'(spd));
      pulse(1, 1'b0);
      wb(ADDR_TIMER_LOW, 1'b1, 8'h00);
      wb(ADDR_SLIP_CTRL, 1'b1, 8'h20);
      wb(ADDR_FEEDBACK_N, 1'b1, 8'h00);
      repeat (2) @(posedge clk);
      ck("zero timer", 8'h00, 8'(spd));
      ramp <= 1'b1;
      repeat (3) @(posedge clk);
      ck("ramp slip", 8'h01, 8'(slip));
      ck("ramp gain", 8'h1f, 8'(gain));
      ramp <= 1'b0;
      repeat (3) @(posedge clk);
      ck("ramp over", 8'h03, 8'(gain));
   endtask
   task automatic t_lock;
      wb(ADDR_PASS_COUNT, 1'b1, 8'h02);
      wb(ADDR_ERR_WINDOW, 1'b1, 8'ha1);
      wb(ADDR_IRQ_STATUS, 1'b1, 8'h0f);
      wb(ADDR_IRQ_MASK, 1'b1, 8'h01);
      gap <= 16'd17000;
      pulse(1, 1'b1);
      ck("early lock", 8'h00, 8'(elock));
      pulse(4, 1'b1);
      ck("lock", 8'h01, 8'(elock));
      ck("combined", 8'h01, 8'(comb));
      ck("irq on", 8'h01, 8'(irq));
      wb(ADDR_IRQ_STATUS, 1'b0, 8'h00);
      ck("lock status", 8'h01, q & 8'h01);
      wb(ADDR_IRQ_STATUS, 1'b1, 8'h01);
      @(posedge clk);
      ck("irq cleared", 8'h00, 8'(irq));
      hi <= 1'b1;
      repeat (6) @(posedge clk);
      ck("pump high", 8'h00, 8'(comb));
      hi <= 1'b0;
      repeat (6) @(posedge clk);
      ck("pump ok", 8'h01, 8'(comb));
      lo <= 1'b1;
      repeat (6) @(posedge clk);
      ck("pump low", 8'h00, 8'(comb));
      lo <= 1'b0;
      wb(ADDR_IRQ_MASK, 1'b1, 8'h00);
      gap <= 16'd20000;
      pulse(3, 1'b1);
      ck("unlock", 8'h00, 8'(elock));
      ck("irq masked", 8'h00, 8'(irq));
      wb(ADDR_ERR_WINDOW, 1'b1, 8'hc1);
      gap <= 16'd0;
      pulse(5, 1'b1);
      ck("reserved window", 8'h00, 8'(elock));
   endtask
   initial begin
      {clk, rstn, cyc, stb, we, rf, fb, ramp, lo, hi} = '0;
      adr = '0;
      wdat = '0;
      gap = '0;
      err_total = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      t_regs();
      t_flags();
      t_speed();
      t_lock();
      end_sim();
   end
   // A hang anywhere ends the run as a mismatch
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      end_sim();
   end
endmodule

// ---- pfl_pkg.sv ----
/*
 Package for the fast-lock, lock-detect and pump-monitor block.
 Assumes a classic Wishbone slave with 32-bit data on a single 200 MHz clock.
*/
// Functional notes
// - Slip factor multiplies R and N while speeding
// - Speedup gain drives pump only while speeding
// - Writing feedback divider starts speedup timer
// - Timer is 11-bit field times 32
// - Timer expiry restores normal gain and divides
// - Below low limit drops combined lock
// - Low flag reads one above low limit
// - Above high limit drops combined lock
// - High flag reads one above high limit
// - Lock after good count with few errors
// - Bad edge limit tolerated before unlock
// - Edge pair inside window is good
// - Window codes 1 to 18 ns, 6-7 reserved
// - Combined lock is edge lock AND pump good
package pfl_pkg;
   localparam logic [7:0]  ADDR_SLIP_CTRL   = 8'h1b;
   localparam logic [7:0]  ADDR_NORM_GAIN   = 8'h1c;
   localparam logic [7:0]  ADDR_FEEDBACK_N  = 8'h10;
   localparam logic [7:0]  ADDR_GAIN_TIMERH = 8'h1d;
   localparam logic [7:0]  ADDR_PUMP_LOW    = 8'h1e;
   localparam logic [7:0]  ADDR_PUMP_HIGH   = 8'h1f;
   localparam logic [7:0]  ADDR_TIMER_LOW   = 8'h20;
   localparam logic [7:0]  ADDR_PASS_COUNT  = 8'h21;
   localparam logic [7:0]  ADDR_ERR_WINDOW  = 8'h22;
   localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h40;
   localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h41;
   localparam logic [7:0]  ADDR_STATUS      = 8'h42;
   localparam logic [7:0]  RST_SLIP_CTRL    = 8'h00;
   localparam logic [7:0]  RST_GAIN_TIMERH  = 8'h00;
   localparam logic [7:0]  RST_TIMER_LOW    = 8'h00;
   localparam logic [5:0]  RST_LOW_LIMIT    = 6'h0a;
   localparam logic [5:0]  RST_HIGH_LIMIT   = 6'h32;
   localparam logic [7:0]  RST_PASS_COUNT   = 8'hff;
   localparam logic [7:0]  RST_ERR_WINDOW   = 8'h00;
   localparam logic [15:0] TIMER_SCALE      = 16'h0020;
   localparam int          CLK_PS           = 5000;
   localparam logic [2:0]  WIN_RESERVED     = 3'h6;
   localparam int          IRQ_W            = 4;
   localparam int          IRQ_LOCK_GAIN    = 0;
   localparam int          IRQ_LOCK_LOSS    = 1;
   localparam int          IRQ_SPEED_DONE   = 2;
   localparam int          IRQ_PUMP_BAD     = 3;
   typedef enum logic [1:0] {
      PFL_SLIP_OFF = 2'b00,
      PFL_SLIP_X2  = 2'b01,
      PFL_SLIP_X4  = 2'b10,
      PFL_SLIP_RSV = 2'b11
   } pfl_slip_t;
endpackage
